//--- hdl/scc_speed_cross_checker.sv
// speed cross checker: compares two encoder speeds, apb registers
// assumes synchronous inputs on ref_clk, apb master on same clock
`timescale 1ns/1ps
`include "scc_params.svh"

module scc_speed_cross_checker #(
   parameter logic [31:0] RECOVERY_CYC = `SCC_RECOVERY_CYC,
   parameter logic [21:0] TSTEP_CYC = 22'(`SCC_TSTEP_CYC)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // encoder inputs
   input wire scc_pkg::scc_encoder_record_type_t motion_in1,
   input wire scc_pkg::scc_encoder_record_type_t motion_in2,
   // optional control inputs
   input wire logic err_reset,
   input wire logic inhibit,
   input wire logic tol2_enable,
   input wire logic tol3_enable,
   // outputs
   output scc_pkg::scc_encoder_record_type_t motion_out,
   output logic mon_status,
   output logic irq
);

   scc_pkg::scc_regs_t r;
   scc_pkg::scc_regs_t next_r;

   logic signed [16:0] s1;
   logic signed [16:0] s2;
   logic [16:0] a1;
   logic [16:0] a2;
   logic [16:0] diff;
   logic [16:0] hi;
   logic [6:0] ratio_sel;
   logic [13:0] tmax_sel;
   logic [23:0] diff_pct;
   logic [23:0] hi_pct;
   logic [6:0] lo_sel;
   logic [23:0] lo_pct;
   logic lo_bad;
   logic lo_fail;
   logic abs_bad;
   logic ratio_bad;
   logic raised;
   logic raise_expired;
   logic dev_bad;
   logic fail_now;
   logic run;
   logic acc;
   logic wr;
   scc_pkg::scc_mode_t mode;

   // ----------------------------------------------------------
   // deviation evaluation
   // ----------------------------------------------------------
   always_comb
   begin
      mode = scc_pkg::scc_mode_t'(r.ctrl[`SCC_CTRL_MODE_LO +: 2]);
      run = r.ctrl[`SCC_CTRL_RUN];
      s1 = {motion_in1.speed[15], motion_in1.speed};
      s2 = {motion_in2.speed[15], motion_in2.speed};
      a1 = s1[16] ? 17'(-s1) : 17'(s1);
      a2 = s2[16] ? 17'(-s2) : 17'(s2);
      hi = (a1 > a2) ? a1 : a2;
      if (mode == scc_pkg::SCC_MODE_SIGNED)
      begin
         diff = (s1 > s2) ? 17'(s1 - s2) : 17'(s2 - s1);
      end
      else
      begin
         diff = (a1 > a2) ? 17'(a1 - a2) : 17'(a2 - a1);
      end
      // ------------------------------------------------------
      // tolerance selection
      // ------------------------------------------------------
      raised = 1'b0;
      ratio_sel = r.ratio1;
      lo_sel = r.ratio1;
      tmax_sel = 14'h0000;
      if (tol3_enable && r.ctrl[`SCC_CTRL_TOL3_EN])
      begin
         raised = 1'b1;
         ratio_sel = r.ratio3;
         lo_sel = r.ratio2;
         tmax_sel = r.tmax3;
      end
      else if (tol2_enable && r.ctrl[`SCC_CTRL_TOL2_EN])
      begin
         raised = 1'b1;
         ratio_sel = r.ratio2;
         tmax_sel = r.tmax2;
      end
      // time limit on raised tolerance, zero unlimited
      raise_expired = raised && (tmax_sel != 14'h0000) &&
         (r.raise_cnt >= tmax_sel);
      if (raise_expired)
      begin
         ratio_sel = r.ratio1;
      end
      diff_pct = 24'(diff) * 24'd100;
      hi_pct = 24'(hi) * 24'(ratio_sel);
      abs_bad = (r.abs_lim != 15'h0000) && (diff > 17'(r.abs_lim));
      ratio_bad = diff_pct > hi_pct;
      lo_pct = 24'(hi) * 24'(lo_sel);
      lo_bad = diff_pct > lo_pct;
      lo_fail = (mode != scc_pkg::SCC_MODE_OFF) && abs_bad && lo_bad;
      dev_bad = (mode != scc_pkg::SCC_MODE_OFF) && abs_bad &&
         ratio_bad;
      fail_now = dev_bad &&
         !(inhibit && r.ctrl[`SCC_CTRL_INH_EN]);
   end

   assign acc = psel && penable;
   assign wr = acc && pwrite;

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      // ------------------------------------------------------
      // raised tolerance timer
      // ------------------------------------------------------
      // count time the lower limit is exceeded, 4 ms steps
      if (raised && lo_fail && run)
      begin
         if (r.step_cnt >= TSTEP_CYC - 22'h000001)
         begin
            next_r.step_cnt = 22'h000000;
            if (r.raise_cnt != 14'h3fff)
            begin
               next_r.raise_cnt = r.raise_cnt + 14'h0001;
            end
         end
         else
         begin
            next_r.step_cnt = r.step_cnt + 22'h000001;
         end
      end
      else if (!raised)
      begin
         next_r.step_cnt = 22'h000000;
         next_r.raise_cnt = 14'h0000;
      end
      // ------------------------------------------------------
      // monitor state machine
      // ------------------------------------------------------
      // one evaluation every cycle
      unique case (r.st)
         scc_pkg::SCC_ST_IDLE:
         begin
            next_r.mon_status = 1'b1;
            if (run)
            begin
               next_r.st = scc_pkg::SCC_ST_OK;
            end
         end
         scc_pkg::SCC_ST_OK:
         begin
            if (fail_now)
            begin
               next_r.st = scc_pkg::SCC_ST_FAIL;
               next_r.mon_status = 1'b0;
            end
         end
         scc_pkg::SCC_ST_FAIL:
         begin
            if (!dev_bad)
            begin
               next_r.st = scc_pkg::SCC_ST_RECOVER;
               next_r.rec_cnt = 32'h0000_0000;
            end
         end
         scc_pkg::SCC_ST_RECOVER:
         begin
            if (fail_now)
            begin
               next_r.st = scc_pkg::SCC_ST_FAIL;
            end
            else if (r.rec_cnt >= RECOVERY_CYC - 32'h0000_0001)
            begin
               next_r.st = scc_pkg::SCC_ST_OK;
               next_r.mon_status = 1'b1;
            end
            else
            begin
               next_r.rec_cnt = r.rec_cnt + 32'h0000_0001;
            end
         end
      endcase
      if (err_reset && r.ctrl[`SCC_CTRL_RST_EN] &&
         r.st != scc_pkg::SCC_ST_IDLE && !fail_now)
      begin
         next_r.st = scc_pkg::SCC_ST_OK;
         next_r.mon_status = 1'b1;
      end
      if (!run)
      begin
         next_r.st = scc_pkg::SCC_ST_IDLE;
         next_r.mon_status = 1'b1;
      end
      // ------------------------------------------------------
      // motion output forwarding
      // ------------------------------------------------------
      // forward record with speed status from result
      next_r.motion_out = motion_in1;
      next_r.motion_out.speed_ok = motion_in1.speed_ok &&
         next_r.mon_status;
      // ------------------------------------------------------
      // apb register access
      // ------------------------------------------------------
      if (psel && !penable)
      begin
         next_r.pready = 1'b1;
      end
      if (acc && r.pready && !pwrite)
      begin
         next_r.pready = 1'b0;
      end
      if (acc && r.pready)
      begin
         next_r.pready = 1'b0;
      end
      if (acc && !r.pready)
      begin
         next_r.pready = 1'b1;
      end
      if (psel && !penable)
      begin
         unique case (paddr)
            `SCC_OFS_CTRL: next_r.prdata = {25'h0, r.ctrl[6:0]};
            `SCC_OFS_ABS: next_r.prdata = {17'h0, r.abs_lim};
            `SCC_OFS_RATIO: next_r.prdata = {9'h0, r.ratio3, 1'b0,
               r.ratio2, 1'b0, r.ratio1};
            `SCC_OFS_TMAX: next_r.prdata = {2'h0, r.tmax3, 2'h0, r.tmax2};
            `SCC_OFS_STAT: next_r.prdata = {29'h0, r.st, r.mon_status};
            `SCC_OFS_IRQ_STAT: next_r.prdata = {30'h0, r.irq_stat};
            `SCC_OFS_IRQ_MASK: next_r.prdata = {30'h0, r.irq_mask};
            `SCC_OFS_OUT: next_r.prdata = {14'h0, r.motion_out};
            default: next_r.pslverr = 1'b1;
         endcase
      end
      if (wr && r.pready)
      begin
         unique case (paddr)
            `SCC_OFS_CTRL: next_r.ctrl = {25'h0, pwdata[6:0]};
            `SCC_OFS_ABS: next_r.abs_lim = pwdata[14:0];
            `SCC_OFS_RATIO:
            begin
               next_r.ratio1 = pwdata[6:0];
               next_r.ratio2 = pwdata[14:8];
               next_r.ratio3 = pwdata[22:16];
            end
            `SCC_OFS_TMAX:
            begin
               next_r.tmax2 = pwdata[13:0];
               next_r.tmax3 = pwdata[29:16];
            end
            `SCC_OFS_IRQ_STAT:
               next_r.irq_stat = r.irq_stat & ~pwdata[1:0];
            `SCC_OFS_IRQ_MASK: next_r.irq_mask = pwdata[1:0];
            default: next_r.pslverr = 1'b0;
         endcase
      end
      // ------------------------------------------------------
      // interrupt flags
      // ------------------------------------------------------
      // sticky events win over clear: fail and recover
      if (r.st != scc_pkg::SCC_ST_FAIL &&
         next_r.st == scc_pkg::SCC_ST_FAIL)
      begin
         next_r.irq_stat[0] = 1'b1;
      end
      if (!r.mon_status && next_r.mon_status)
      begin
         next_r.irq_stat[1] = 1'b1;
      end
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.st <= scc_pkg::SCC_ST_IDLE;
         r.mon_status <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------
   // output ports
   // ----------------------------------------------------------
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;
   assign motion_out = r.motion_out;
   assign mon_status = r.mon_status;
   assign irq = r.irq;

endmodule

//--- hdl/scc_params.svh
// speed cross checker constants: offsets, fields, resets, timing
// assumes a 100 MHz ref_clk and a 32-bit apb register bus
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define SCC_OFS_CTRL 12'h000
`define SCC_OFS_ABS 12'h004
`define SCC_OFS_RATIO 12'h008
`define SCC_OFS_TMAX 12'h00c
`define SCC_OFS_STAT 12'h010
`define SCC_OFS_IRQ_STAT 12'h014
`define SCC_OFS_IRQ_MASK 12'h018
`define SCC_OFS_OUT 12'h01c

// -------------------------------------------------------------
// control fields
// -------------------------------------------------------------
`define SCC_CTRL_RUN 0
`define SCC_CTRL_MODE_LO 1
`define SCC_CTRL_RST_EN 3
`define SCC_CTRL_INH_EN 4
`define SCC_CTRL_TOL2_EN 5
`define SCC_CTRL_TOL3_EN 6

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define SCC_CTRL_RESET 32'h0000_0000
`define SCC_ABS_RESET 15'h0000
`define SCC_RATIO_RESET 7'h00

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define SCC_CLK_HZ 100000000
`define SCC_RECOVERY_S 1
`define SCC_RECOVERY_CYC (`SCC_RECOVERY_S * `SCC_CLK_HZ)
`define SCC_TSTEP_MS 4
`define SCC_TSTEP_CYC (`SCC_TSTEP_MS * (`SCC_CLK_HZ / 1000))
`define SCC_TMAX_MS_MAX 60000

`endif

//--- hdl/scc_pkg.sv
// speed cross checker types
// assumes nothing beyond the params header
package scc_pkg;

   // ----------------------------------------------------------
   // encoder motion data record
   // ----------------------------------------------------------
   typedef struct packed {
      logic [15:0] speed;
      logic speed_ok;
      logic valid;
   } scc_encoder_record_type_t;

   // ----------------------------------------------------------
   // cross check modes
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      SCC_MODE_OFF = 2'b00,
      SCC_MODE_SIGNED = 2'b01,
      SCC_MODE_UNSIGNED = 2'b10
   } scc_mode_t;

   // ----------------------------------------------------------
   // monitor state
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      SCC_ST_IDLE = 2'b00,
      SCC_ST_OK = 2'b01,
      SCC_ST_FAIL = 2'b10,
      SCC_ST_RECOVER = 2'b11
   } scc_state_t;

   typedef struct packed {
      scc_state_t st;
      logic [31:0] ctrl;
      logic [14:0] abs_lim;
      logic [6:0] ratio1;
      logic [6:0] ratio2;
      logic [6:0] ratio3;
      logic [13:0] tmax2;
      logic [13:0] tmax3;
      logic [31:0] rec_cnt;
      logic [21:0] step_cnt;
      logic [13:0] raise_cnt;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic mon_status;
      logic irq;
      scc_encoder_record_type_t motion_out;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } scc_regs_t;

endpackage

//--- dv/scc_checker_assertions.sv
// checker for the speed cross checker ports
// assumes it is bound into scc_speed_cross_checker
`timescale 1ns/1ps
module scc_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // apb handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // motion records
   input wire scc_pkg::scc_encoder_record_type_t motion_in1,
   input wire scc_pkg::scc_encoder_record_type_t motion_in2,
   input wire scc_pkg::scc_encoder_record_type_t motion_out,
   // status
   input wire logic mon_status,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   sequence s_same;
      motion_in1.speed == motion_in2.speed;
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   property p_start;
      $rose(rst_n) |-> mon_status && !irq;
   endproperty
   property p_same;
      s_same [*2] |=> !$fell(mon_status);
   endproperty
   property p_hold;
      $fell(mon_status) |-> !mon_status [*8];
   endproperty
   property p_speed;
      1'h1 |=> motion_out.speed == $past(motion_in1.speed);
   endproperty
   property p_valid;
      1'h1 |=> motion_out.valid == $past(motion_in1.valid);
   endproperty
   property p_ok;
      1'h1 |=> motion_out.speed_ok ==
         (mon_status && $past(motion_in1.speed_ok));
   endproperty
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_once;
      pready |=> !pready;
   endproperty
   a_start: assert property (p_start) else $error("start");
   a_same: assert property (p_same) else $error("fell");
   a_hold: assert property (p_hold) else $error("rose");
   a_speed: assert property (p_speed) else $error("speed");
   a_valid: assert property (p_valid) else $error("valid");
   a_ok: assert property (p_ok) else $error("speed ok");
   a_ready: assert property (p_ready) else $error("ready");
   a_once: assert property (p_once) else $error("ready");
endmodule
bind scc_speed_cross_checker scc_checker scc_checker_inst (.ref_clk,
   .rst_n, .psel, .penable, .pready, .motion_in1, .motion_in2,
   .motion_out, .mon_status, .irq);

//--- dv/scc_encoder_pair.sv
// encoder pair model: two independent encoders feeding records
// assumes the bench commands both speeds on ref_clk
`timescale 1ns/1ps
module scc_encoder_pair (
   // clock
   input wire logic ref_clk,
   // commanded speeds
   input wire logic [15:0] sp1,
   input wire logic [15:0] sp2,
   // motion records
   output scc_pkg::scc_encoder_record_type_t rec1 = 18'h0,
   output scc_pkg::scc_encoder_record_type_t rec2 = 18'h0
);
   // one record per encoder each cycle
   always_ff @(posedge ref_clk)
   begin
      rec1 <= {sp1, 2'h3};
      rec2 <= {sp2, 2'h3};
   end
endmodule

//--- dv/test_speed_cross_checker.sv
// speed cross checker bench: apb set-up, fault and recovery
// assumes recovery of 50 cycles, 10-cycle time step, encoder model
`timescale 1ns/1ps
module test_speed_cross_checker;
   localparam int REC = 50;
   logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, pready, pslverr, mon_status, irq, e;
   logic err_reset = 1'h0, inhibit = 1'h0;
   logic tol2_enable = 1'h0, tol3_enable = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [15:0] sp1 = 16'h0, sp2 = 16'h0;
   scc_pkg::scc_encoder_record_type_t motion_in1, motion_in2, motion_out;
   int num_errors = 0, n_tests = 0;
   scc_speed_cross_checker #(.RECOVERY_CYC(32'(REC)), .TSTEP_CYC(22'ha))
   scc_speed_cross_checker_inst (.ref_clk, .rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .motion_in1,
      .motion_in2, .err_reset, .inhibit, .tol2_enable, .tol3_enable,
      .motion_out, .mon_status, .irq);
   scc_encoder_pair scc_encoder_pair_inst (.ref_clk, .sp1, .sp2,
      .rec1(motion_in1), .rec2(motion_in2));
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input logic c, input string m);
      n_tests++;
      if (c !== 1'h1)
      begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
         @(posedge ref_clk);
      while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic spd(input logic [15:0] a, input logic [15:0] b);
      @(posedge ref_clk);
      sp1 <= a;
      sp2 <= b;
   endtask
   task automatic clr;
      spd(16'h3e8, 16'h3e8);
      cyc(3);
      err_reset <= 1'h1;
      cyc(1);
      err_reset <= 1'h0;
      cyc(2);
      chk(mon_status === 1'h1, "reset input");
      apb(1'h1, 12'h014, 32'h3);
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset;
      chk(mon_status === 1'h1 && irq === 1'h0, "reset out");
      apb(1'h0, 12'h000, 32'h0);
      chk(q === 32'h0 && e === 1'h0, "ctrl reset");
      apb(1'h0, 12'h020, 32'h0);
      chk(e === 1'h1 && q === 32'h0, "unmapped");
   endtask
   task automatic t_fail;
      apb(1'h1, 12'h004, 32'ha);
      apb(1'h1, 12'h008, 32'h5a3c0a);
      apb(1'h1, 12'h018, 32'h1);
      apb(1'h0, 12'h008, 32'h0);
      chk(q === 32'h005a3c0a && e === 1'h0, "ratio read");
      apb(1'h1, 12'h000, 32'hb);
      spd(16'h3e8, 16'h3e8);
      cyc(4);
      chk(mon_status === 1'h1 && irq === 1'h0, "equal");
      spd(16'h3e8, 16'h1f4);
      cyc(4);
      chk(mon_status === 1'h0 && irq === 1'h1, "deviation");
      chk(motion_out.speed_ok === 1'h0, "out status");
      apb(1'h0, 12'h010, 32'h0);
      chk(q === 32'h4 && e === 1'h0, "stat fail");
      spd(16'h3e8, 16'h3e8);
      cyc(REC - 10);
      chk(mon_status === 1'h0, "early");
      cyc(15);
      chk(mon_status === 1'h1, "recovered");
      apb(1'h1, 12'h014, 32'h3);
      cyc(2);
      chk(irq === 1'h0, "irq clear");
   endtask
   task automatic t_sign;
      apb(1'h1, 12'h018, 32'h0);
      apb(1'h1, 12'h000, 32'hd);
      spd(16'h64, 16'hff9c);
      cyc(4);
      chk(mon_status === 1'h1, "unsigned");
      apb(1'h1, 12'h000, 32'h9);
      spd(16'h3e8, 16'h0);
      cyc(4);
      chk(mon_status === 1'h1, "mode off");
      apb(1'h1, 12'h000, 32'hb);
      spd(16'h64, 16'hff9c);
      cyc(4);
      chk(mon_status === 1'h0 && irq === 1'h0, "signed");
      cyc(8);
      clr;
   endtask
   task automatic t_tol;
      spd(16'ha, 16'h2);
      cyc(4);
      chk(mon_status === 1'h1, "abs limit");
      tol2_enable <= 1'h1;
      apb(1'h1, 12'h000, 32'h2b);
      spd(16'h3e8, 16'h1f4);
      cyc(6);
      chk(mon_status === 1'h1, "limit 2");
      apb(1'h1, 12'h00c, 32'h50000);
      tol3_enable <= 1'h1;
      apb(1'h1, 12'h000, 32'h6b);
      spd(16'h3e8, 16'hc8);
      cyc(5);
      chk(mon_status === 1'h1, "limit 3");
      cyc(60);
      chk(mon_status === 1'h0, "time limit");
      tol2_enable <= 1'h0;
      tol3_enable <= 1'h0;
      cyc(8);
      clr;
   endtask
   task automatic t_inh;
      inhibit <= 1'h1;
      apb(1'h1, 12'h000, 32'h1b);
      spd(16'h3e8, 16'h1f4);
      cyc(5);
      chk(mon_status === 1'h1, "inhibited");
      inhibit <= 1'h0;
      cyc(4);
      chk(mon_status === 1'h0, "released");
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_reset;
      t_fail;
      t_sign;
      t_tol;
      t_inh;
      summarize;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      summarize;
   end
endmodule
